// *** rtl/sfpf_defines.svh ***
// register offsets, field positions, reset values and control codes of the fault and production bank
`ifndef SFPF_DEFINES_SVH
`define SFPF_DEFINES_SVH

`define SFPF_ADDR_W          4
`define SFPF_OFF_INT_FAULT   4'h0
`define SFPF_OFF_STK_FAULT   4'h1
`define SFPF_OFF_PROD_WORD   4'h2
`define SFPF_OFF_CONTROL     4'h3
`define SFPF_OFF_COMMAND     4'h4
`define SFPF_OFF_SWITCH_OUT  4'h5

`define SFPF_INT_COMMANDED   7
`define SFPF_INT_COMP_MUX    6
`define SFPF_INT_GROUND      5
`define SFPF_INT_REFERENCE   4
`define SFPF_INT_SLOW_OSC    3
`define SFPF_INT_INSTR_ROM   2
`define SFPF_INT_DATA_ROM    1
`define SFPF_INT_FUSE_MEM    0
`define SFPF_STK_TOP         0

`define SFPF_PW_FUSE_WR_EN   7
`define SFPF_PW_PF_CHECK_EN  6
`define SFPF_PW_PREDSG_TEST  5
`define SFPF_PW_NORMAL_FET   4
`define SFPF_PW_DISCHARGE_SWITCH_TEST_ON     2
`define SFPF_PW_CHARGE_SWITCH_TEST_ON     1
`define SFPF_PW_PRECHG_TEST  0
`define SFPF_PW_USED_MASK    16'h00F7

`define SFPF_PROD_RESET      16'h00D0
`define SFPF_CMD_PRECHG      2'h0
`define SFPF_CMD_CHG         2'h1
`define SFPF_CMD_DSG         2'h2
`define SFPF_CMD_PREDSG      2'h3
`define SFPF_FUSE_SRC_PF     2'h0
`define SFPF_FUSE_SRC_BLOWN  2'h1
`define SFPF_FUSE_SRC_MANU   2'h2

`endif

// *** rtl/sfpf_pkg.sv ***
// types shared by the fault and production bank
package sfpf_pkg;
	typedef enum logic [1:0] {
		SFPF_BUS_IDLE = 2'b00,
		SFPF_BUS_ACK  = 2'b01
	} sfpf_bus_state_t;
endpackage : sfpf_pkg

// *** rtl/sfpf_sync3.sv ***
// three-stage synchroniser, change accepted when the last two stages agree
module sfpf_sync3 (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_o <= s3_reg;
			end
		end
	end
endmodule : sfpf_sync3

// *** rtl/sfpf_fuse_gate.sv ***
// decides whether a runtime fuse memory write may proceed
`include "sfpf_defines.svh"
module sfpf_fuse_gate (
	input  wire logic       write_enable_i,
	input  wire logic       config_update_i,
	input  wire logic       unrestricted_i,
	input  wire logic       limits_ok_i,
	input  wire logic [1:0] source_i,
	output logic            allow_o
);
	logic manu_ok;
	logic src_ok;
	assign manu_ok = (source_i != `SFPF_FUSE_SRC_MANU) || unrestricted_i;
	assign src_ok  = (source_i == `SFPF_FUSE_SRC_PF) || (source_i == `SFPF_FUSE_SRC_BLOWN)
		|| (source_i == `SFPF_FUSE_SRC_MANU);
	assign allow_o = limits_ok_i && src_ok && manu_ok
		&& (write_enable_i || config_update_i);
endmodule : sfpf_fuse_gate

// *** rtl/sfpf_bank.sv ***
// saved fault flags, production status word and switch test control
// Overview of operation
// - bit 7: commanded failure occurred
// - bit 6: comparator mux failure occurred
// - bits 5,4: ground, reference failures
// - bit 3: slow oscillator monitor failure
// - bits 2,1: instruction, data ROM failures
// - bit 0: fuse memory failure
// - stack register bit 0 top failure
// - production word 16 bits, some reserved
// - bit 7 allows runtime fuse writes
// - runtime writes: failure, blown, records
// - program only within voltage, temperature limits
// - config update mode still allows programming
// - bit 6 gates failure checking
// - bit 4 low: test mode control
// - bit 4 high: ignore test commands
// - safety overrides always win
// - bit 5 predischarge test state
// - bit 2 discharge test state
// - bit 1 charge test state
// - bit 0 precharge test state
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`include "sfpf_defines.svh"
module sfpf_bank (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic [`SFPF_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	output logic      [1:0]             avs_response,
	input  wire logic [7:0]             int_fault_event_i,
	input  wire logic                   stack_fault_event_i,
	input  wire logic                   config_update_i,
	input  wire logic                   unrestricted_access_mode_i,
	input  wire logic                   fuse_limits_ok_i,
	input  wire logic                   fuse_write_req_i,
	input  wire logic [1:0]             fuse_write_src_i,
	input  wire logic [3:0]             normal_switch_on_i,
	input  wire logic [3:0]             safety_force_off_i,
	input  wire logic [3:0]             safety_force_on_i,
	input  wire logic                   fault_pin_i,
	output logic                        fuse_write_go_o,
	output logic                        pf_check_enable_o,
	output logic      [3:0]             switch_on_o
);
	// switch order in vectors: 3 predischarge, 2 discharge, 1 charge, 0 precharge
	sfpf_pkg::sfpf_bus_state_t state_reg;
	sfpf_pkg::sfpf_bus_state_t state_next;
	logic [7:0]  int_fault_reg;
	logic        stk_fault_reg;
	logic [15:0] prod_reg;
	logic [15:0] prod_next;
	logic [7:0]  int_set;
	logic        fault_pin_sync;
	logic        fuse_allow;
	logic        permanent_failure_check_enable;
	logic        test_mode;
	logic        wr_hit;
	logic        cmd_wr;
	logic        ctl_wr;
	logic [1:0]  cmd_code;
	logic [3:0]  test_bits;
	logic [3:0]  switch_next;
	logic [31:0] rd_mux;
	logic        addr_ok;

	sfpf_sync3 u_fault_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (fault_pin_i),
		.q_o   (fault_pin_sync)
	);

	sfpf_fuse_gate u_fuse_gate (
		.write_enable_i  (prod_reg[`SFPF_PW_FUSE_WR_EN]),
		.config_update_i (config_update_i),
		.unrestricted_i  (unrestricted_access_mode_i),
		.limits_ok_i     (fuse_limits_ok_i),
		.source_i        (fuse_write_src_i),
		.allow_o         (fuse_allow)
	);

	assign permanent_failure_check_enable     = prod_reg[`SFPF_PW_PF_CHECK_EN];
	assign test_mode = ~prod_reg[`SFPF_PW_NORMAL_FET];
	// commanded failure arrives as a pin or on event bit 7, others from internal monitors
	assign int_set = {int_fault_event_i[7] | fault_pin_sync, int_fault_event_i[6:0]}
		& {8{permanent_failure_check_enable}};

	// bus decode
	assign addr_ok = (avs_address <= `SFPF_OFF_SWITCH_OUT);
	// writes commit on the edge that ends the wait, as the master sees it
	assign wr_hit  = (state_reg == sfpf_pkg::SFPF_BUS_ACK) && avs_write;
	assign ctl_wr  = wr_hit && (avs_address == `SFPF_OFF_CONTROL) && avs_byteenable[0];
	assign cmd_wr  = wr_hit && (avs_address == `SFPF_OFF_COMMAND) && avs_byteenable[0];
	assign cmd_code = avs_writedata[1:0];

	// test commands toggle their bit only in test mode
	always_comb begin
		prod_next = prod_reg;
		if (ctl_wr) begin
			prod_next[`SFPF_PW_FUSE_WR_EN]  = avs_writedata[`SFPF_PW_FUSE_WR_EN];
			prod_next[`SFPF_PW_PF_CHECK_EN] = avs_writedata[`SFPF_PW_PF_CHECK_EN];
			prod_next[`SFPF_PW_NORMAL_FET]  = avs_writedata[`SFPF_PW_NORMAL_FET];
		end
		if (cmd_wr && test_mode) begin
			case (cmd_code)
				`SFPF_CMD_PREDSG: prod_next[`SFPF_PW_PREDSG_TEST] =
					~prod_reg[`SFPF_PW_PREDSG_TEST];
				`SFPF_CMD_DSG:    prod_next[`SFPF_PW_DISCHARGE_SWITCH_TEST_ON] =
					~prod_reg[`SFPF_PW_DISCHARGE_SWITCH_TEST_ON];
				`SFPF_CMD_CHG:    prod_next[`SFPF_PW_CHARGE_SWITCH_TEST_ON] =
					~prod_reg[`SFPF_PW_CHARGE_SWITCH_TEST_ON];
				default:          prod_next[`SFPF_PW_PRECHG_TEST] =
					~prod_reg[`SFPF_PW_PRECHG_TEST];
			endcase
		end
		prod_next = prod_next & `SFPF_PW_USED_MASK;
	end

	assign test_bits = {prod_reg[`SFPF_PW_PREDSG_TEST], prod_reg[`SFPF_PW_DISCHARGE_SWITCH_TEST_ON],
		prod_reg[`SFPF_PW_CHARGE_SWITCH_TEST_ON], prod_reg[`SFPF_PW_PRECHG_TEST]};

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_switch
			assign switch_next[g] = safety_force_off_i[g] ? 1'b0 :
				safety_force_on_i[g] ? 1'b1 :
				(test_mode ? test_bits[g] : normal_switch_on_i[g]);
		end
	endgenerate

	// read mux, reserved bits zero
	always_comb begin
		case (avs_address)
			`SFPF_OFF_INT_FAULT:  rd_mux = {24'h000000, int_fault_reg};
			`SFPF_OFF_STK_FAULT:  rd_mux = {31'h00000000, stk_fault_reg};
			`SFPF_OFF_PROD_WORD:  rd_mux = {16'h0000, prod_reg};
			`SFPF_OFF_CONTROL:    rd_mux = {16'h0000, prod_reg};
			`SFPF_OFF_SWITCH_OUT: rd_mux = {28'h0000000, switch_on_o};
			default:              rd_mux = 32'h00000000;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sfpf_pkg::SFPF_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					state_next = sfpf_pkg::SFPF_BUS_ACK;
				end
			end
			sfpf_pkg::SFPF_BUS_ACK: state_next = sfpf_pkg::SFPF_BUS_IDLE;
			default: state_next = sfpf_pkg::SFPF_BUS_IDLE;
		endcase
	end

	// bus slave: one wait cycle then answer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg       <= sfpf_pkg::SFPF_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			avs_response    <= 2'h0;
		end else begin
			state_reg       <= state_next;
			avs_waitrequest <= ~(state_reg == sfpf_pkg::SFPF_BUS_IDLE && (avs_read || avs_write));
			if (state_reg == sfpf_pkg::SFPF_BUS_IDLE && avs_read) begin
				avs_readdata <= rd_mux;
			end
			if (state_reg == sfpf_pkg::SFPF_BUS_IDLE) begin
				avs_response <= addr_ok ? 2'h0 : 2'h3;
			end
		end
	end

	// sticky saved failure flags
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			int_fault_reg <= 8'h00;
			stk_fault_reg <= 1'b0;
		end else begin
			int_fault_reg <= int_fault_reg | int_set;
			stk_fault_reg <= stk_fault_reg | (stack_fault_event_i & permanent_failure_check_enable);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prod_reg          <= `SFPF_PROD_RESET;
			switch_on_o       <= 4'h0;
			fuse_write_go_o   <= 1'b0;
			pf_check_enable_o <= 1'b0;
		end else begin
			prod_reg          <= prod_next;
			switch_on_o       <= switch_next;
			fuse_write_go_o   <= fuse_write_req_i & fuse_allow;
			pf_check_enable_o <= permanent_failure_check_enable;
		end
	end
endmodule : sfpf_bank

// *** verification/sfpf_chk.sv ***
// concurrent checks on the ports of the fault and production bank
module sfpf_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	input wire logic [3:0]  safety_force_off_i,
	input wire logic [3:0]  safety_force_on_i,
	input wire logic        config_update_i,
	input wire logic        unrestricted_access_mode_i,
	input wire logic        fuse_limits_ok_i,
	input wire logic        fuse_write_req_i,
	input wire logic [1:0]  fuse_write_src_i,
	input wire logic        fuse_write_go_o,
	input wire logic [3:0]  switch_on_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = (avs_read || avs_write) && avs_waitrequest;
	wire ans = avs_read && !avs_waitrequest;
	chk_wait_answer: assert property (req |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	chk_resp_unmapped: assert property (req && avs_address > 4'h5
		|=> avs_response == 2'h3 && (avs_write || avs_readdata == 32'h0))
		else $error("unmapped access not refused");
	chk_force_off: assert property ((switch_on_o & $past(safety_force_off_i)) == 4'h0)
		else $error("forced-off switch driven on");
	chk_force_on: assert property (!$past(rst_i)
		|-> (~switch_on_o & $past(safety_force_on_i & ~safety_force_off_i)) == 4'h0)
		else $error("forced-on switch not driven");
	chk_fuse_limits: assert property (fuse_write_go_o
		|-> $past(fuse_write_req_i && fuse_limits_ok_i))
		else $error("fuse write outside limits");
	chk_fuse_config: assert property (config_update_i && fuse_limits_ok_i
		&& fuse_write_req_i && fuse_write_src_i != 2'h3
		&& (fuse_write_src_i != 2'h2 || unrestricted_access_mode_i) |=> fuse_write_go_o)
		else $error("fuse write refused in config update");
	chk_fuse_record: assert property (fuse_write_go_o
		&& $past(fuse_write_src_i == 2'h2 && !config_update_i) |-> $past(unrestricted_access_mode_i))
		else $error("record write without unrestricted access");
	chk_stack_reserved: assert property (ans && avs_address == 4'h1
		|-> avs_readdata[31:1] == 31'h0)
		else $error("stack register reserved bits set");
	chk_word_reserved: assert property (ans && avs_address == 4'h2
		|-> (avs_readdata & 32'hFFFFFF08) == 32'h0)
		else $error("production word reserved bits set");
	cov_read: cover property (ans);
	cov_fuse: cover property (fuse_write_go_o);
	cov_force: cover property (safety_force_off_i != 4'h0);
endmodule : sfpf_chk

bind sfpf_bank sfpf_chk i_chk (
	.clk_i                      (clk_i),
	.rst_i                      (rst_i),
	.avs_address                (avs_address),
	.avs_read                   (avs_read),
	.avs_write                  (avs_write),
	.avs_readdata               (avs_readdata),
	.avs_waitrequest            (avs_waitrequest),
	.avs_response               (avs_response),
	.safety_force_off_i         (safety_force_off_i),
	.safety_force_on_i          (safety_force_on_i),
	.config_update_i            (config_update_i),
	.unrestricted_access_mode_i (unrestricted_access_mode_i),
	.fuse_limits_ok_i           (fuse_limits_ok_i),
	.fuse_write_req_i           (fuse_write_req_i),
	.fuse_write_src_i           (fuse_write_src_i),
	.fuse_write_go_o            (fuse_write_go_o),
	.switch_on_o                (switch_on_o)
);

// *** verification/sfpf_host.sv ***
// host model issuing register reads and subcommand writes
module sfpf_host (
	input  wire logic        clk_i,
	input  wire logic        wait_i,
	input  wire logic [31:0] rdata_i,
	output logic      [3:0]  addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [31:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {addr_o, rd_o, wr_o, wdata_o} = 38'h0;
	// request held until waitrequest is seen low
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		{addr_o, wr_o, rd_o, wdata_o} <= {a, w, !w, d};
		do @(posedge clk_i); while (wait_i !== 1'b0);
		q = rdata_i;
		{rd_o, wr_o} <= 2'h0;
	endtask : xfer
endmodule : sfpf_host

// *** verification/sfpf_bank_tb.sv ***
// self-checking bench for the fault and production bank
module sfpf_bank_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e; logic [3:0] s;} sfpf_row_t;
	logic        clk_i = 1'h0, rst_i = 1'h1, cfg = 1'h0, unr = 1'h0, lim = 1'h0, req = 1'h0;
	logic        pstk = 1'h0, pin = 1'h0, rd, wr, wait_o, go, pfe;
	logic [1:0]  src = 2'h0, resp;
	logic [7:0]  ev = 8'h0;
	logic [3:0]  nrm = 4'h2, foff = 4'h0, fon = 4'h0, addr, sw;
	logic [31:0] wd, rdt, q;
	int          n_fail = 0, n_checks = 0;
	sfpf_row_t rows [11] = '{'{4'h3, 8'hC0, 8'hC0, 4'h0}, '{4'h4, 8'h00, 8'hC1, 4'h1},
		'{4'h4, 8'h01, 8'hC3, 4'h3}, '{4'h4, 8'h02, 8'hC7, 4'h7}, '{4'h4, 8'h03, 8'hE7, 4'hF},
		'{4'h4, 8'h01, 8'hE5, 4'hD}, '{4'h3, 8'hFF, 8'hF5, 4'h2}, '{4'h4, 8'h00, 8'hF5, 4'h2},
		'{4'h2, 8'h00, 8'hF5, 4'h2}, '{4'h6, 8'h00, 8'h00, 4'h2}, '{4'h3, 8'h90, 8'hB5, 4'h2}};
	sfpf_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdt),
		.avs_waitrequest(wait_o), .avs_response(resp), .int_fault_event_i(ev),
		.stack_fault_event_i(pstk), .config_update_i(cfg), .unrestricted_access_mode_i(unr),
		.fuse_limits_ok_i(lim), .fuse_write_req_i(req), .fuse_write_src_i(src),
		.normal_switch_on_i(nrm), .safety_force_off_i(foff), .safety_force_on_i(fon),
		.fault_pin_i(pin), .fuse_write_go_o(go), .pf_check_enable_o(pfe), .switch_on_o(sw));
	sfpf_host i_host (.clk_i(clk_i), .wait_i(wait_o), .rdata_i(rdt), .addr_o(addr),
		.rd_o(rd), .wr_o(wr), .wdata_o(wd));
	initial forever #20 clk_i = ~clk_i;
	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task rdchk(input logic [3:0] a, input logic [31:0] e);
		i_host.xfer(1'h0, a, 32'h0, q);
		check("readdata", q, e);
	endtask : rdchk
	task wrt(input logic [3:0] a, input logic [31:0] d);
		i_host.xfer(1'h1, a, d, q);
	endtask : wrt
	task pulse(input logic [7:0] e, input logic s);
		@(posedge clk_i);
		{ev, pstk} <= {e, s};
		repeat (2) @(posedge clk_i);
		{ev, pstk} <= 9'h0;
	endtask : pulse
	task fuse(input logic c, input logic u, input logic l, input logic [1:0] s, input logic e);
		@(posedge clk_i);
		{cfg, unr, lim, src, req} <= {c, u, l, s, 1'h1};
		@(posedge clk_i);
		req <= 1'h0;
		#1 check("fuse_go", go, e);
	endtask : fuse
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	initial begin
		#100us;
		n_fail++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		rdchk(4'h2, 32'hD0);
		foreach (rows[i]) begin
			wrt(rows[i].a, {24'h0, rows[i].d});
			rdchk(rows[i].a == 4'h6 ? 4'h6 : 4'h2,
				{24'h0, rows[i].e});
			check("switch_on", sw, rows[i].s);
		end
		$display("test rows done");
		check("pf_enable", pfe, 1'h0);
		pulse(8'hFF, 1'h1);
		rdchk(4'h0, 32'h0);
		rdchk(4'h1, 32'h0);
		wrt(4'h3, 32'hD0);
		// commanded failure through the synchronised pin
		@(posedge clk_i);
		pin <= 1'h1;
		repeat (5) @(posedge clk_i);
		pin <= 1'h0;
		rdchk(4'h0, 32'h80);
		pulse(8'hA5, 1'h0);
		rdchk(4'h0, 32'hA5);
		pulse(8'h5A, 1'h1);
		rdchk(4'h0, 32'hFF);
		rdchk(4'h1, 32'h1);
		@(posedge clk_i);
		{foff, fon} <= {4'h2, 4'h3};
		repeat (2) @(posedge clk_i);
		#1 check("switch_on", sw, 4'h1);
		rdchk(4'h5, 32'h1);
		$display("fault and safety test done");
		fuse(1'h0, 1'h0, 1'h1, 2'h0, 1'h1);
		fuse(1'h0, 1'h0, 1'h1, 2'h1, 1'h1);
		fuse(1'h0, 1'h0, 1'h1, 2'h2, 1'h0);
		fuse(1'h0, 1'h1, 1'h1, 2'h2, 1'h1);
		fuse(1'h0, 1'h0, 1'h0, 2'h0, 1'h0);
		wrt(4'h3, 32'h50);
		fuse(1'h0, 1'h0, 1'h1, 2'h0, 1'h0);
		fuse(1'h1, 1'h0, 1'h1, 2'h0, 1'h1);
		$display("fuse test done");
		@(posedge clk_i);
		rst_i <= 1'h1;
		@(posedge clk_i);
		#1 check("waitrequest", wait_o, 1'h1);
		check("switch_on", sw, 4'h0);
		@(posedge clk_i);
		rst_i <= 1'h0;
		rdchk(4'h0, 32'h0);
		rdchk(4'h2, 32'hD0);
		$display("reset test done");
		results();
	end
endmodule : sfpf_bank_tb
